/* pkg/tcc_pkg.sv */
// How it works
// R1: Up count wraps to zero, sets overflow flag
// R2: Center mode sets flag when turning down
// R3: Flag clears on armed read then zero write
// R4: New overflow restarts the clear sequence
// R5: Writing one to the flag does nothing
// R6: Interrupt asserts when flag and enable set
// R7: Center select gives up/down counting
// R8: Clock source zero stops, one selects bus
// R9: Code two fixed clock, three external
// R10: Fixed and external clocks are synchronised
// R11: External clock at most quarter bus rate
// R12: Prescaler follows source select and synchroniser
// R13: Prescale value n divides by two^n
// R14: Capture value reads latch both bytes
// R15: Compare bytes transfer after both written
// R16: Channel control write unlatches byte buffers
// R17: Sixteen-bit counter with sixteen-bit modulo limit
// R18: Counter holds during debug background mode
// R19: Stop mode halts, wait mode runs
package tcc_pkg;
    // Address width and register byte offsets on the bus
    localparam int AW = 12;
    localparam logic [11:0] OFS_SC = 12'h000;
    localparam logic [11:0] OFS_CNT = 12'h004;
    localparam logic [11:0] OFS_MOD = 12'h008;
    localparam logic [11:0] OFS_CSC = 12'h00C;
    localparam logic [11:0] OFS_CVH = 12'h010;
    localparam logic [11:0] OFS_CVL = 12'h014;
    // Field positions
    localparam int FLAG_BIT = 7;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 4;
    // Clock source codes and channel capture mode code
    localparam logic [1:0] CLK_OFF = 2'h0;
    localparam logic [1:0] CLK_BUS = 2'h1;
    localparam logic [1:0] CLK_FIX = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [1:0] MODE_CAPT = 2'h0;
    // Prescaler counter width, enough for divide by 128
    localparam int PRE_W = 7;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timer status/control layout
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic center;
        logic [1:0] src_sel;
        logic [2:0] div_sel;
    } tcc_sc_t;

    // Whole state of the core
    typedef struct packed {
        tcc_sc_t sc;
        logic armed;
        logic [15:0] cnt;
        logic [15:0] modv;
        logic down;
        logic [PRE_W-1:0] pre;
        logic [7:0] csc;
        logic irq;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcc_state_t;

    localparam tcc_state_t ST_RST = '{awready: 1'b1, wready: 1'b1,
        arready: 1'b1, default: '0};

    // Channel value latch state
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] buffer;
        logic rlatch;
        logic rhi_first;
        logic whi;
        logic wlo;
    } tcc_chan_t;

    // Synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tcc_sync_t;
endpackage

/* design/tcc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rising edge pulse
module tcc_sync (
    input wire logic mclk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic sig_in, // Asynchronous level
    output logic rise // One-cycle pulse on rise
);
    tcc_pkg::tcc_sync_t s; // Registered state
    tcc_pkg::tcc_sync_t n; // Next state

    // First stage feeds only the second
    always_comb
    begin
        n = s;
        n.s1 = sig_in;
        n.s2 = s.s1;
        n.s3 = s.s2;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    // Edge taken from settled stages only
    assign rise = s.s2 & ~s.s3;
endmodule
`default_nettype wire

/* design/tcc_chan.sv */
`timescale 1ns/1ps
`default_nettype none
// One channel value register with coherent byte latch
module tcc_chan (
    input wire logic mclk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic capture_mode, // Channel in input capture
    input wire logic cap_pulse, // Capture event
    input wire logic [15:0] count, // Main counter
    input wire logic rd_hi, // High byte read
    input wire logic rd_lo, // Low byte read
    input wire logic wr_hi, // High byte write
    input wire logic wr_lo, // Low byte write
    input wire logic [7:0] wbyte, // Write byte
    input wire logic ctl_wr, // Channel control written
    output logic [7:0] hi_byte, // High byte as read
    output logic [7:0] lo_byte // Low byte as read
);
    tcc_pkg::tcc_chan_t s; // Registered state
    tcc_pkg::tcc_chan_t n; // Next state

    always_comb
    begin
        n = s;
        if (capture_mode)
        begin
            // Capture keeps going; buffered copy stays for software
            if (cap_pulse)
            begin
                n.value = count;
            end
            if ((rd_hi | rd_lo) && !s.rlatch)
            begin
                n.buffer = s.value; // [R14]
                n.rlatch = 1'b1; // [R14]
                n.rhi_first = rd_hi;
            end
            else if ((rd_hi && !s.rhi_first) || (rd_lo && s.rhi_first))
            begin
                n.rlatch = 1'b0; // [R14]
            end
        end
        else
        begin
            // Bytes gather in the buffer in either order
            if (wr_hi)
            begin
                n.buffer[15:8] = wbyte; // [R15]
                n.whi = 1'b1;
            end
            if (wr_lo)
            begin
                n.buffer[7:0] = wbyte; // [R15]
                n.wlo = 1'b1;
            end
            if (n.whi && n.wlo)
            begin
                n.value = n.buffer; // [R15]
                n.whi = 1'b0;
                n.wlo = 1'b0;
            end
        end
        // Control write drops any half-done sequence
        if (ctl_wr)
        begin
            n.rlatch = 1'b0; // [R16]
            n.whi = 1'b0; // [R16]
            n.wlo = 1'b0; // [R16]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    // Latched copy wins while a read pair is open
    assign hi_byte = s.rlatch ? s.buffer[15:8] : s.value[15:8];
    assign lo_byte = s.rlatch ? s.buffer[7:0] : s.value[7:0];
endmodule
`default_nettype wire

/* design/tcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Timer main counter, global control and AXI4-Lite register slave
module tcc_core (
    input wire logic mclk, // Bus clock, 100 MHz
    input wire logic rst, // Sync reset, active high
    input wire logic fix_clk_in, // Fixed system clock level
    input wire logic ext_clk_in, // External clock pin
    input wire logic cap_in, // Channel capture pin
    input wire logic dbg_halt, // Debug background mode active
    input wire logic stop_mode, // Stop mode, clocks gone
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic s_axi_bvalid, // Write response valid
    output logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic s_axi_rvalid, // Read data valid
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rready, // Read data ready
    output logic overflow_irq, // Overflow interrupt request
    output logic center_pwm_mode, // Center-aligned select
    output logic [15:0] count_value // Main counter
);
    tcc_pkg::tcc_state_t s; // Registered state
    tcc_pkg::tcc_state_t n; // Next state

    logic aw_fire; // Address taken
    logic w_fire; // Data taken
    logic ar_fire; // Read address taken
    logic wr_do; // Write executes now
    logic [11:0] waddr; // Effective write address
    logic [31:0] wdat; // Effective write data
    logic [3:0] wst; // Effective byte enables
    tcc_pkg::tcc_sc_t wsc; // Write data as control fields
    logic wr_sc; // Status/control write
    logic cnt_wr; // Counter write, manual reset
    logic rd_sc; // Status/control read
    logic fix_pulse; // Synchronised fixed clock edge
    logic ext_pulse; // Synchronised external edge
    logic cap_pulse; // Synchronised capture edge
    logic src_pulse; // Selected source edge
    logic run; // Source edge while not halted
    logic [tcc_pkg::PRE_W-1:0] pre_mask; // Prescale mask
    logic pre_tick; // Counter advance
    logic [15:0] lim; // Effective modulo
    logic ovf; // Overflow event this cycle
    logic [7:0] ch_hi; // Channel high byte
    logic [7:0] ch_lo; // Channel low byte
    logic [31:0] rd_mux; // Read data selection
    logic rd_ok; // Read address mapped
    logic wr_ok; // Write address mapped

    // Bus handshakes
    assign aw_fire = s_axi_awvalid & s.awready;
    assign w_fire = s_axi_wvalid & s.wready;
    assign ar_fire = s_axi_arvalid & s.arready;
    assign waddr = s.aw_have ? s.awaddr : s_axi_awaddr;
    assign wdat = s.w_have ? s.wdata : s_axi_wdata;
    assign wst = s.w_have ? s.wstrb : s_axi_wstrb;
    assign wsc = wdat[7:0];
    // Both halves present and no response pending
    assign wr_do = (s.aw_have | aw_fire) & (s.w_have | w_fire) & ~s.bvalid;
    assign wr_sc = wr_do && waddr == tcc_pkg::OFS_SC && wst[0];
    assign cnt_wr = wr_do && waddr == tcc_pkg::OFS_CNT;
    assign rd_sc = ar_fire && s_axi_araddr == tcc_pkg::OFS_SC;

    // Clock inputs pass a synchroniser before use
    tcc_sync u_fix (
        .mclk(mclk),
        .rst(rst),
        .sig_in(fix_clk_in),
        .rise(fix_pulse)
    ); // [R10]
    tcc_sync u_ext (
        .mclk(mclk),
        .rst(rst),
        .sig_in(ext_clk_in),
        .rise(ext_pulse)
    ); // [R10]
    tcc_sync u_cap (
        .mclk(mclk),
        .rst(rst),
        .sig_in(cap_in),
        .rise(cap_pulse)
    );

    // Source select; external rate must stay under a quarter of mclk
    always_comb
    begin
        case (s.sc.src_sel)
            tcc_pkg::CLK_BUS: src_pulse = 1'b1; // [R8]
            tcc_pkg::CLK_FIX: src_pulse = fix_pulse; // [R9]
            tcc_pkg::CLK_EXT: src_pulse = ext_pulse; // [R9] [R11]
            default: src_pulse = 1'b0; // [R8]
        endcase
    end

    // Debug and stop freeze the count; wait mode has no effect
    assign run = src_pulse & ~dbg_halt & ~stop_mode; // [R18] [R19]
    // Divide by two to the n after the source mux
    assign pre_mask = tcc_pkg::PRE_W'((8'h01 << s.sc.div_sel) - 8'h01); // [R13]
    assign pre_tick = run && ((s.pre & pre_mask) == pre_mask); // [R12]
    // Zero modulo means free running over the full range
    assign lim = (s.modv == tcc_pkg::CNT_ZERO) ? tcc_pkg::CNT_FULL : s.modv;

    // Channel value register with byte latching
    tcc_chan u_chan (
        .mclk(mclk),
        .rst(rst),
        .capture_mode(s.csc[tcc_pkg::MODE_HI:tcc_pkg::MODE_LO]
            == tcc_pkg::MODE_CAPT && !s.sc.center),
        .cap_pulse(cap_pulse),
        .count(s.cnt),
        .rd_hi(ar_fire && s_axi_araddr == tcc_pkg::OFS_CVH),
        .rd_lo(ar_fire && s_axi_araddr == tcc_pkg::OFS_CVL),
        .wr_hi(wr_do && waddr == tcc_pkg::OFS_CVH && wst[0]),
        .wr_lo(wr_do && waddr == tcc_pkg::OFS_CVL && wst[0]),
        .wbyte(wdat[7:0]),
        .ctl_wr(wr_do && waddr == tcc_pkg::OFS_CSC && wst[0]),
        .hi_byte(ch_hi),
        .lo_byte(ch_lo)
    );

    // Read data mux
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            tcc_pkg::OFS_SC: rd_mux = 32'(s.sc);
            tcc_pkg::OFS_CNT: rd_mux = 32'(s.cnt);
            tcc_pkg::OFS_MOD: rd_mux = 32'(s.modv);
            tcc_pkg::OFS_CSC: rd_mux = 32'(s.csc);
            tcc_pkg::OFS_CVH: rd_mux = 32'(ch_hi);
            tcc_pkg::OFS_CVL: rd_mux = 32'(ch_lo);
            default:
            begin
                rd_mux = '0;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Unmapped writes answer with an error and change nothing
    assign wr_ok = waddr == tcc_pkg::OFS_SC || waddr == tcc_pkg::OFS_CNT
        || waddr == tcc_pkg::OFS_MOD || waddr == tcc_pkg::OFS_CSC
        || waddr == tcc_pkg::OFS_CVH || waddr == tcc_pkg::OFS_CVL;

    // Next state of the whole core
    always_comb
    begin
        n = s;
        ovf = 1'b0;
        if (run)
        begin
            n.pre = s.pre + 1'b1;
        end
        // Counter step
        if (pre_tick)
        begin
            if (!s.sc.center)
            begin
                n.down = 1'b0; // [R7]
                if (s.cnt >= lim)
                begin
                    n.cnt = tcc_pkg::CNT_ZERO; // [R1]
                    ovf = 1'b1; // [R1]
                end
                else
                begin
                    n.cnt = s.cnt + tcc_pkg::CNT_ONE; // [R17]
                end
            end
            else if (!s.down)
            begin
                // Up leg of center-aligned counting
                if (s.cnt >= lim)
                begin
                    n.down = 1'b1; // [R7]
                    n.cnt = s.cnt - tcc_pkg::CNT_ONE; // [R2]
                    ovf = 1'b1; // [R2]
                end
                else
                begin
                    n.cnt = s.cnt + tcc_pkg::CNT_ONE;
                end
            end
            else if (s.cnt == tcc_pkg::CNT_ZERO)
            begin
                // Bottom turn
                n.down = 1'b0;
                n.cnt = tcc_pkg::CNT_ONE;
            end
            else
            begin
                n.cnt = s.cnt - tcc_pkg::CNT_ONE;
            end
        end
        // Any counter write clears count and prescaler
        if (cnt_wr)
        begin
            n.cnt = tcc_pkg::CNT_ZERO;
            n.pre = '0;
            n.down = 1'b0;
        end
        if (wr_do && waddr == tcc_pkg::OFS_MOD)
        begin
            if (wst[0])
            begin
                n.modv[7:0] = wdat[7:0];
            end
            if (wst[1])
            begin
                n.modv[15:8] = wdat[15:8];
            end
        end
        if (wr_do && waddr == tcc_pkg::OFS_CSC && wst[0])
        begin
            n.csc = wdat[7:0];
        end
        // A read that sees the flag arms the clear
        if (rd_sc && s.sc.flag)
        begin
            n.armed = 1'b1; // [R3]
        end
        if (wr_sc)
        begin
            n.sc.irq_en = wsc.irq_en;
            n.sc.center = wsc.center; // [R7]
            n.sc.src_sel = wsc.src_sel; // [R8]
            n.sc.div_sel = wsc.div_sel; // [R12]
            // Writing one leaves the flag alone
            if (!wsc.flag && s.armed)
            begin
                n.sc.flag = 1'b0; // [R3] [R5]
            end
            n.armed = 1'b0;
        end
        // Set wins over clear and restarts the sequence
        if (ovf)
        begin
            n.sc.flag = 1'b1; // [R1] [R2]
            n.armed = 1'b0; // [R4]
        end
        n.irq = n.sc.flag & n.sc.irq_en; // [R6]
        // Write channel
        if (aw_fire)
        begin
            n.awready = 1'b0;
            n.aw_have = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (w_fire)
        begin
            n.wready = 1'b0;
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (wr_do)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        // Read channel, one outstanding read
        if (ar_fire)
        begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = rd_mux;
            n.rresp = rd_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
        end
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s <= tcc_pkg::ST_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // Outputs straight from state
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign overflow_irq = s.irq;
    assign center_pwm_mode = s.sc.center;
    assign count_value = s.cnt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_up_wrap;
        pre_tick && !s.sc.center && s.cnt == lim && !cnt_wr
            |=> s.cnt == tcc_pkg::CNT_ZERO && s.sc.flag;
    endproperty
    a_up_wrap: assert property (p_up_wrap) // [R1]
        else $error("up count did not wrap with flag");

    property p_center_turn;
        pre_tick && s.sc.center && !s.down && s.cnt == lim && !cnt_wr
            |=> s.down && s.sc.flag && s.cnt == $past(s.cnt) - 16'h0001;
    endproperty
    a_center_turn: assert property (p_center_turn) // [R2]
        else $error("center turn wrong");

    sequence s_arm_read;
        rd_sc && s.sc.flag && !ovf && !wr_sc;
    endsequence
    property p_arm;
        s_arm_read |=> s.armed;
    endproperty
    a_arm: assert property (p_arm) // [R3]
        else $error("flag read did not arm clear");

    property p_no_clear_unarmed;
        wr_sc && !s.armed && s.sc.flag |=> s.sc.flag;
    endproperty
    a_no_clear_unarmed: assert property (p_no_clear_unarmed) // [R3]
        else $error("flag cleared without read");

    property p_restart;
        s.armed && ovf |=> !s.armed && s.sc.flag;
    endproperty
    a_restart: assert property (p_restart) // [R4]
        else $error("overflow did not restart clear");

    property p_write_one;
        wr_sc && wsc.flag && s.sc.flag |=> s.sc.flag;
    endproperty
    a_write_one: assert property (p_write_one) // [R5]
        else $error("write of one changed flag");

    property p_irq;
        s.sc.flag && s.sc.irq_en |-> overflow_irq;
    endproperty
    a_irq: assert property (p_irq) // [R6]
        else $error("irq missing");

    property p_off_hold;
        s.sc.src_sel == tcc_pkg::CLK_OFF && !cnt_wr |=> $stable(s.cnt);
    endproperty
    a_off_hold: assert property (p_off_hold) // [R8]
        else $error("counter moved with clock off");

    property p_debug_hold;
        (dbg_halt || stop_mode) && !cnt_wr |=> $stable(s.cnt);
    endproperty
    a_debug_hold: assert property (p_debug_hold) // [R18]
        else $error("counter moved while halted");

    property p_div1;
        s.sc.src_sel == tcc_pkg::CLK_BUS && s.sc.div_sel == 3'h0
            && !dbg_halt && !stop_mode && !s.sc.center && s.cnt < lim
            && !cnt_wr
            |=> s.cnt == $past(s.cnt) + 16'h0001;
    endproperty
    a_div1: assert property (p_div1) // [R13]
        else $error("divide by one did not count");
endmodule
`default_nettype wire

/* verification/tcc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the timer core
module tb;
    logic mclk = 1'b0; // Bus clock
    logic rst = 1'b1; // Sync reset
    logic fx = 1'b0; // Fixed clock level
    logic ex = 1'b0; // External clock pin
    logic cap = 1'b0; // Capture pin
    logic dbg = 1'b0; // Debug halt
    logic stp = 1'b0; // Stop mode
    logic [11:0] awa = 12'h000; // Write address
    logic [11:0] ara = 12'h000; // Read address
    logic [31:0] wd = 32'h0000_0000; // Write data
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic awr, wrd, bv, arr, rv, irq, cpm; // Design outputs
    logic [1:0] br, rr, rp; // Responses
    logic [31:0] rdd, d; // Read data
    logic [15:0] cv, c0, x, mx; // Counter samples
    logic dn; // Down step seen
    int n_fail = 0;
    int n_tests = 0;
    int i;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    tcc_core i_dut (.mclk(mclk), .rst(rst), .fix_clk_in(fx),
        .ext_clk_in(ex), .cap_in(cap), .dbg_halt(dbg), .stop_mode(stp),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bvalid(bv), .s_axi_bresp(br),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rvalid(rv), .s_axi_rdata(rdd),
        .s_axi_rresp(rr), .s_axi_rready(rry), .overflow_irq(irq),
        .center_pwm_mode(cpm), .count_value(cv));

    // One comparison, counted
    task automatic chk(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Counter advance since c0, modulo 16 bits
    task automatic dchk(input string n, input logic [15:0] e);
        logic [15:0] t;
        t = cv - c0;
        chk(n, e, t);
    endtask

    // Write: both channels offered at once, bready held up to bvalid
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge mclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (ta && tw && bv)
                break;
            if (awr && !ta)
            begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (wrd && !tw)
            begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        rp = br;
        bry <= 1'b0;
    endtask

    // Read: data and response taken at the rvalid edge
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic ta;
        ta = 1'b0;
        @(posedge mclk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (ta && rv)
                break;
            if (arr && !ta)
            begin
                ta = 1'b1;
                arv <= 1'b0;
            end
        end
        v = rdd;
        rp = rr;
        rry <= 1'b0;
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e,
        input string n);
        logic [31:0] v;
        rd(a, v);
        chk(n, e, v);
    endtask

    // Peak count and any downward step to a nonzero count over 40 cycles
    task automatic obs();
        logic [15:0] p;
        mx = 16'h0000;
        dn = 1'b0;
        p = cv;
        repeat (40)
        begin
            @(posedge mclk);
            if (cv > mx)
                mx = cv;
            if (cv < p && cv != 16'h0000)
                dn = 1'b1;
            p = cv;
        end
    endtask

    // Capture pulse long enough for the synchroniser
    task automatic pulse();
        cap <= 1'b1;
        cyc(6);
        cap <= 1'b0;
        cyc(6);
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog, far beyond the few thousand cycles needed
    initial
    begin
        cyc(40000);
        n_fail++;
        stop_test();
    end

    initial
    begin
        cyc(16);
        rst <= 1'b0;
        rc(12'h000, 8'h00, "sc_reset");
        chk("rd_okay", 2'h0, rp);
        rc(12'h004, 8'h00, "cnt_off");
        wr(12'h008, 8'h03);
        chk("wr_okay", 2'h0, rp);
        wr(12'h000, 8'h48);
        obs();
        chk("up_peak", 8'h03, mx);
        chk("up_only", 1'b0, dn);
        rc(12'h000, 8'hc8, "flag_up");
        chk("irq_on", 1'b1, irq);
        // Overflows land between this arming read and the write
        cyc(8);
        // Clearing write also stops the count, so only a restart keeps it
        wr(12'h000, 8'h40);
        rc(12'h000, 8'hc0, "rearm");
        wr(12'h000, 8'hc0);
        rc(12'h000, 8'hc0, "write_one");
        wr(12'h000, 8'h40);
        rc(12'h000, 8'h40, "clear");
        wr(12'h000, 8'h08);
        cyc(10);
        wr(12'h000, 8'h00);
        chk("irq_masked", 1'b0, irq);
        wr(12'h000, 8'h00);
        rc(12'h000, 8'h80, "no_arm");
        wr(12'h000, 8'h00);
        $display("Test flag done");
        wr(12'h000, 8'h28);
        chk("center_out", 1'b1, cpm);
        obs();
        chk("ctr_peak", 8'h03, mx);
        chk("ctr_down", 1'b1, dn);
        rc(12'h000, 8'ha8, "flag_ctr");
        $display("Test center done");
        wr(12'h008, 8'h00);
        for (i = 0; i < 8; i++)
        begin
            wr(12'h000, 8'h08 | i[7:0]);
            wr(12'h004, 8'h00);
            cyc(2);
            c0 = cv;
            cyc(256);
            dchk("prescale", 16'(256 >> i));
        end
        $display("Test prescale done");
        for (i = 0; i < 4; i++)
        begin
            wr(12'h000, 8'(i << 3));
            cyc(4);
            c0 = cv;
            // Source period of 8 bus cycles, under a quarter rate
            repeat (16)
            begin
                fx <= 1'b1;
                ex <= 1'b1;
                cyc(4);
                fx <= 1'b0;
                ex <= 1'b0;
                cyc(4);
            end
            cyc(8);
            dchk("source", i == 0 ? 0 : (i == 1 ? 136 : 16));
        end
        $display("Test source done");
        wr(12'h000, 8'h08);
        for (i = 0; i < 2; i++)
        begin
            dbg <= (i == 0);
            stp <= (i == 1);
            cyc(3);
            c0 = cv;
            cyc(20);
            dchk("halted", 16'h0000);
            dbg <= 1'b0;
            stp <= 1'b0;
            cyc(3);
            c0 = cv;
            cyc(20);
            dchk("resumed", 16'h0014);
        end
        $display("Test halt done");
        wr(12'h00c, 8'h10);
        wr(12'h014, 8'h34);
        rc(12'h014, 8'h00, "lo_only");
        wr(12'h010, 8'h12);
        rc(12'h010, 8'h12, "pair_hi");
        rc(12'h014, 8'h34, "pair_lo");
        wr(12'h010, 8'h56);
        wr(12'h00c, 8'h10);
        wr(12'h014, 8'h78);
        rc(12'h010, 8'h12, "unlatched");
        wr(12'h010, 8'h9a);
        rc(12'h010, 8'h9a, "hi_first");
        rc(12'h014, 8'h78, "hi_first_lo");
        wr(12'h000, 8'h00);
        wr(12'h00c, 8'h00);
        wr(12'h000, 8'h08);
        cyc(300);
        wr(12'h000, 8'h00);
        x = cv;
        pulse();
        rc(12'h010, x[15:8], "cap_hi");
        wr(12'h000, 8'h08);
        cyc(300);
        wr(12'h000, 8'h00);
        pulse();
        rc(12'h014, x[7:0], "cap_lo");
        x = cv;
        rc(12'h014, x[7:0], "cap2_lo");
        rc(12'h010, x[15:8], "cap2_hi");
        $display("Test channel done");
        rd(12'h0fc, d);
        chk("bad_data", 32'h0000_0000, d);
        chk("bad_resp", 2'h2, rp);
        wr(12'h0fc, 32'h0000_00ff);
        chk("bad_wresp", 2'h2, rp);
        $display("Test unmapped done");
        stop_test();
    end
endmodule
`default_nettype wire
